// ### include/usart_slave_pkg.sv
// constants for the synchronous slave serial port
package usart_slave_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h19;
  localparam logic [7:0] IDX_RECEIVE_BUFFER = 8'h1a;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;
  localparam int ADDR_WIDTH = 12;
  // interrupt_control fields
  localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
  localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT = 6;
  // peripheral_irq_flags / peripheral_irq_enables fields
  localparam int RECEIVE_FLAG_BIT = 5;
  localparam int TRANSMIT_FLAG_BIT = 4;
  // receive_status_control fields
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_RECEIVE_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int RECEIVE_NINTH_BIT = 0;
  localparam logic [7:0] RECEIVE_CONTROL_WRITE_MASK = 8'hf0;
  // transmit_status_control fields
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int NINE_BIT_TRANSMIT_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT = 5;
  localparam int SYNC_MODE_BIT = 4;
  localparam int SHIFTER_EMPTY_BIT = 1;
  localparam int TRANSMIT_NINTH_BIT = 0;
  localparam logic [7:0] TRANSMIT_CONTROL_WRITE_MASK = 8'hf5;
  // reset values
  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_RESET = 8'h00;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRANSMIT_HOLDING_RESET = 8'h00;
  localparam logic [7:0] RECEIVE_BUFFER_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_RESET = 8'h00;
  localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h02;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
  // word lengths and buffering
  localparam logic [3:0] WORD_LEN_EIGHT = 4'h8;
  localparam logic [3:0] WORD_LEN_NINE = 4'h9;
  localparam logic [1:0] RX_FIFO_DEPTH = 2'h2;
  localparam logic [15:0] INTERRUPT_VECTOR = 16'h0004;
endpackage : usart_slave_pkg

// ### rtl/usart_sync_slave.sv
// synchronous slave serial port with apb registers
//
// Overview of operation
// - external master drives shift clock; never driven
// - slave when sync set, clock source clear
// - shifting continues while the core sleeps
// - buffering and flags as master mode
// - first word moves to shifter at once
// - second word held; transmit flag stays clear
// - after shift-out, reload shifter, then flag
// - transmit flag with enables wakes the core
// - wake vectors to 0004h only with global enable
// - single receive enable ignored in slave
// - continuous receive works during sleep, fills buffer
// - receive flag with enables wakes the core
// - completed reception sets receive buffer full flag
// - clearing continuous receive clears error flags
// - receive data sampled on falling clock edge
// - two-deep receive buffer with ninth bits
// - overrun when full: flag, drop, block
// - buffer read exposes next word's ninth bit
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module usart_sync_slave (
  input wire logic pclk, // 250 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic shift_clock_pin, // shift clock from the master
  input wire logic serial_data_in, // data pin level
  output logic serial_data_out, // data pin drive value
  output logic serial_data_oe, // data pin driven when high
  input wire logic core_sleeping, // core is in its sleep state
  output logic interrupt_request, // peripheral interrupt pending
  output logic wake_core, // wake request while sleeping
  output logic take_vector, // wake branches to the vector
  output logic [15:0] vector_address // interrupt vector
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] peripheral_irq_enables;
  logic [7:0] receive_control;
  logic [7:0] transmit_control;
  logic [7:0] baud_divisor;
  logic [7:0] transmit_holding;
  logic holding_full;
  logic [8:0] transmit_shifter;
  logic [3:0] tx_count;
  logic tx_busy;
  logic [8:0] receive_shifter;
  logic [3:0] rx_count;
  logic [8:0] rx_fifo [0:1];
  logic rx_head;
  logic [1:0] rx_level;
  logic overrun_error_flag;
  logic sck_s1, sck_s2, sck_s3;
  logic din_s1, din_s2;
  logic [7:0] read_mux;
  logic map_hit;

  wire [7:0] reg_index = paddr[9:2];
  wire access = psel & penable;
  wire wr = access & pwrite & map_hit;
  wire rd = access & ~pwrite & map_hit;
  wire serial_port_enable = receive_control[usart_slave_pkg::SERIAL_PORT_ENABLE_BIT];
  wire nine_bit_receive = receive_control[usart_slave_pkg::NINE_BIT_RECEIVE_BIT];
  wire continuous_receive_enable =
    receive_control[usart_slave_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
  wire clock_source_select = transmit_control[usart_slave_pkg::CLOCK_SOURCE_SELECT_BIT];
  wire nine_bit_transmit = transmit_control[usart_slave_pkg::NINE_BIT_TRANSMIT_BIT];
  wire transmit_enable_bit = transmit_control[usart_slave_pkg::TRANSMIT_ENABLE_BIT];
  wire sync_mode = transmit_control[usart_slave_pkg::SYNC_MODE_BIT];
  wire transmit_ninth_bit = transmit_control[usart_slave_pkg::TRANSMIT_NINTH_BIT];
  wire slave_mode = sync_mode & serial_port_enable & ~clock_source_select;
  // continuous receive alone chooses reception; single receive is ignored
  wire rx_active = slave_mode & continuous_receive_enable;
  wire tx_active = slave_mode & transmit_enable_bit & ~continuous_receive_enable;
  wire sck_rise = sck_s2 & ~sck_s3;
  wire sck_fall = ~sck_s2 & sck_s3;
  wire [3:0] tx_len = nine_bit_transmit ? usart_slave_pkg::WORD_LEN_NINE
                                        : usart_slave_pkg::WORD_LEN_EIGHT;
  wire [3:0] rx_len = nine_bit_receive ? usart_slave_pkg::WORD_LEN_NINE
                                       : usart_slave_pkg::WORD_LEN_EIGHT;
  wire [8:0] next_receive_shifter = {din_s2, receive_shifter[8:1]};
  wire rx_word_done = rx_active & ~overrun_error_flag & sck_fall
                      & (rx_count + 4'h1 == rx_len);
  wire [8:0] rx_word = nine_bit_receive ? next_receive_shifter
                                        : {1'b0, next_receive_shifter[8:1]};
  wire rx_push = rx_word_done & (rx_level != usart_slave_pkg::RX_FIFO_DEPTH);
  wire rx_pop = rd & (reg_index == usart_slave_pkg::IDX_RECEIVE_BUFFER)
                & (rx_level != 2'h0);
  wire tx_done = tx_busy & sck_fall & (tx_count == tx_len);
  wire tx_load = tx_active & ~tx_busy & holding_full;
  wire holding_write = wr & (reg_index == usart_slave_pkg::IDX_TRANSMIT_HOLDING);
  // empty flag only shows once the transmitter is enabled, so it reads clear out of reset
  wire transmit_buffer_empty_flag = ~holding_full & transmit_enable_bit;
  wire receive_buffer_full_flag = rx_level != 2'h0;
  wire [8:0] rx_head_word = rx_fifo[rx_head];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every clock edge from the master is caught at 250 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sck_s1 <= shift_clock_pin;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      din_s1 <= serial_data_in;
      din_s2 <= din_s1;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_comb begin
    map_hit = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    read_mux = 8'h00;
    case (reg_index)
      usart_slave_pkg::IDX_INTERRUPT_CONTROL: read_mux = interrupt_control;
      usart_slave_pkg::IDX_PERIPHERAL_IRQ_FLAGS: begin
        read_mux = peripheral_irq_flags;
        read_mux[usart_slave_pkg::RECEIVE_FLAG_BIT] = receive_buffer_full_flag;
        read_mux[usart_slave_pkg::TRANSMIT_FLAG_BIT] = transmit_buffer_empty_flag;
      end
      usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL: begin
        read_mux = receive_control & usart_slave_pkg::RECEIVE_CONTROL_WRITE_MASK;
        read_mux[usart_slave_pkg::OVERRUN_ERROR_BIT] = overrun_error_flag;
        read_mux[usart_slave_pkg::RECEIVE_NINTH_BIT] = rx_head_word[8];
      end
      usart_slave_pkg::IDX_TRANSMIT_HOLDING: read_mux = 8'h00;
      usart_slave_pkg::IDX_RECEIVE_BUFFER: read_mux = rx_head_word[7:0];
      usart_slave_pkg::IDX_PERIPHERAL_IRQ_ENABLES: read_mux = peripheral_irq_enables;
      usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL: begin
        read_mux = transmit_control & usart_slave_pkg::TRANSMIT_CONTROL_WRITE_MASK;
        read_mux[usart_slave_pkg::SHIFTER_EMPTY_BIT] = ~tx_busy;
      end
      usart_slave_pkg::IDX_BAUD_DIVISOR: read_mux = baud_divisor;
      default: map_hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = access & ~map_hit;

  // read data captured in the setup phase, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h00_0000, read_mux};
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control <= usart_slave_pkg::INTERRUPT_CONTROL_RESET;
      peripheral_irq_flags <= usart_slave_pkg::PERIPHERAL_IRQ_FLAGS_RESET;
      peripheral_irq_enables <= usart_slave_pkg::PERIPHERAL_IRQ_ENABLES_RESET;
      receive_control <= usart_slave_pkg::RECEIVE_STATUS_CONTROL_RESET;
      transmit_control <= usart_slave_pkg::TRANSMIT_STATUS_CONTROL_RESET
                          & usart_slave_pkg::TRANSMIT_CONTROL_WRITE_MASK;
      baud_divisor <= usart_slave_pkg::BAUD_DIVISOR_RESET;
    end else if (wr) begin
      case (reg_index)
        usart_slave_pkg::IDX_INTERRUPT_CONTROL: interrupt_control <= pwdata[7:0];
        usart_slave_pkg::IDX_PERIPHERAL_IRQ_FLAGS: peripheral_irq_flags <= pwdata[7:0];
        usart_slave_pkg::IDX_PERIPHERAL_IRQ_ENABLES: peripheral_irq_enables <= pwdata[7:0];
        usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL:
          receive_control <= pwdata[7:0] & usart_slave_pkg::RECEIVE_CONTROL_WRITE_MASK;
        usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL:
          transmit_control <= pwdata[7:0] & usart_slave_pkg::TRANSMIT_CONTROL_WRITE_MASK;
        usart_slave_pkg::IDX_BAUD_DIVISOR: baud_divisor <= pwdata[7:0];
        default: baud_divisor <= baud_divisor;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit holding register
  // ----------------------------------------------------------------
  // a write in the cycle of a move keeps the holding register full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding <= usart_slave_pkg::TRANSMIT_HOLDING_RESET;
      holding_full <= 1'b0;
    end else if (holding_write) begin
      transmit_holding <= pwdata[7:0];
      holding_full <= 1'b1;
    end else if (tx_load) begin
      holding_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  // bits leave on rising edges; the word ends at the falling edge after the last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_shifter <= 9'h000;
      tx_count <= 4'h0;
      tx_busy <= 1'b0;
      serial_data_out <= 1'b0;
    end else if (~tx_active) begin
      tx_busy <= 1'b0;
      tx_count <= 4'h0;
    end else if (tx_load) begin
      transmit_shifter <= {transmit_ninth_bit, transmit_holding};
      tx_count <= 4'h0;
      tx_busy <= 1'b1;
    end else if (tx_done) begin
      tx_busy <= 1'b0;
    end else if (tx_busy & sck_rise & (tx_count != tx_len)) begin
      serial_data_out <= transmit_shifter[0];
      transmit_shifter <= {1'b0, transmit_shifter[8:1]};
      tx_count <= tx_count + 4'h1;
    end
  end

  assign serial_data_oe = tx_active;

  // ----------------------------------------------------------------
  // receive shifter and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_shifter <= 9'h000;
      rx_count <= 4'h0;
    end else if (~rx_active | overrun_error_flag) begin
      rx_count <= 4'h0;
    end else if (sck_fall) begin
      receive_shifter <= next_receive_shifter;
      rx_count <= rx_word_done ? 4'h0 : rx_count + 4'h1;
    end
  end

  // the overrun flag only falls with continuous receive cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag <= 1'b0;
    end else if (rx_word_done & ~rx_push) begin
      overrun_error_flag <= 1'b1;
    end else if (~continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // two-deep receive buffer
  // ----------------------------------------------------------------
  genvar entry;
  generate
    for (entry = 0; entry < 2; entry++) begin : g_rx_entry
      wire [0:0] tail = rx_head + rx_level[0];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_fifo[entry] <= {1'b0, usart_slave_pkg::RECEIVE_BUFFER_RESET};
        end else if (rx_push & (tail == 1'(entry))) begin
          rx_fifo[entry] <= rx_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_head <= 1'b0;
      rx_level <= 2'h0;
    end else begin
      if (rx_pop) begin
        rx_head <= ~rx_head;
      end
      rx_level <= rx_level + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // ----------------------------------------------------------------
  // wake and vector
  // ----------------------------------------------------------------
  wire global_interrupt_enable = interrupt_control[usart_slave_pkg::GLOBAL_INTERRUPT_ENABLE_BIT];
  wire peripheral_interrupt_enable =
    interrupt_control[usart_slave_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT];
  wire transmit_interrupt_enable =
    peripheral_irq_enables[usart_slave_pkg::TRANSMIT_FLAG_BIT];
  wire receive_interrupt_enable =
    peripheral_irq_enables[usart_slave_pkg::RECEIVE_FLAG_BIT];
  wire pending = peripheral_interrupt_enable
                 & ((transmit_buffer_empty_flag & transmit_interrupt_enable)
                    | (receive_buffer_full_flag & receive_interrupt_enable));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request <= 1'b0;
      wake_core <= 1'b0;
      take_vector <= 1'b0;
    end else begin
      interrupt_request <= pending;
      wake_core <= pending & core_sleeping;
      take_vector <= pending & global_interrupt_enable;
    end
  end

  assign vector_address = usart_slave_pkg::INTERRUPT_VECTOR;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_word_shifted;
    tx_busy & sck_fall & (tx_count == tx_len);
  endsequence

  sequence s_reload;
    tx_active & holding_full & ~holding_write;
  endsequence

  external_clock_a: assert property ($changed(serial_data_out) |-> $past(sck_rise))
    else $error("data out changed off a rising shift clock edge");
  slave_select_a: assert property ($rose(tx_busy) |-> $past(slave_mode))
    else $error("shifter started without slave select");
  first_load_a: assert property (tx_active & ~tx_busy & holding_full & ~holding_write
                                 |=> tx_busy & transmit_buffer_empty_flag)
    else $error("first word not moved to shifter");
  held_flag_a: assert property (holding_full |-> ~transmit_buffer_empty_flag)
    else $error("transmit flag set while holding full");
  reload_a: assert property (s_word_shifted ##0 s_reload
                             |=> ##1 tx_busy & ~holding_full)
    else $error("held word not reloaded after shift out");
  wake_tx_a: assert property (peripheral_interrupt_enable & transmit_interrupt_enable
                              & transmit_buffer_empty_flag & core_sleeping
                              |=> wake_core)
    else $error("transmit flag did not wake core");
  vector_a: assert property (take_vector |-> $past(global_interrupt_enable))
    else $error("vector taken without global enable");
  rx_flag_a: assert property (rx_push |=> receive_buffer_full_flag ##1 interrupt_request
                              || ~receive_interrupt_enable
                              || ~peripheral_interrupt_enable)
    else $error("reception did not raise flag");
  overrun_a: assert property (rx_word_done & ~rx_pop & rx_level == 2'h2
                              |=> overrun_error_flag & rx_level == 2'h2)
    else $error("overrun not flagged or word kept");
  error_clear_a: assert property (~continuous_receive_enable ##1 ~continuous_receive_enable
                                  |-> ~overrun_error_flag)
    else $error("error flag survived receive disable");
  sample_fall_a: assert property (rx_count != $past(rx_count) && rx_count != 4'h0
                                  |-> $past(sck_fall))
    else $error("receive bit taken off a falling edge");
endmodule : usart_sync_slave

// ### testbench/shift_master.sv
// external synchronous master: makes the shift clock, drives or reads the data pin
`timescale 1ns/1ps
module shift_master (
  input wire logic data_line, // resolved data pin level
  output logic shift_clock, // shift clock to the slave
  output logic data_drive, // master data value
  output logic data_oe // master drives the data pin
);
  initial begin
    shift_clock = 1'b0;
    data_drive = 1'b0;
    data_oe = 1'b0;
  end
  // ---------------------------------------------
  // one word, lsb first; clock stands still outside
  // ---------------------------------------------
  task automatic frame(input int bits, input logic drive, input logic [8:0] send,
                       output logic [8:0] seen);
    seen = '0;
    data_oe <= drive;
    for (int i = 0; i < bits; i++) begin
      shift_clock <= 1'b1;
      data_drive <= send[i];
      #32;
      seen[i] = data_line;
      shift_clock <= 1'b0;
      #32;
    end
    data_oe <= 1'b0;
  endtask : frame
endmodule : shift_master

// ### testbench/usart_sync_slave_mode_tb.sv
// self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
module usart_sync_slave_mode_tb;
  logic pclk, presetn, psel, penable, pwrite, core_sleeping, float_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, tx0, tx1;
  logic pready, pslverr, err, sdo, sdo_oe, ck, m_data, m_oe, line, irq, wake, vtake;
  logic [15:0] vec;
  logic [8:0] got, w;
  logic [8:0] rx_model [$];
  logic [7:0] ridx [8];
  logic [7:0] rval [8];
  int failures, checks_done, cycles;
  // released pin shows a changing level, never the last driven one
  assign line = sdo_oe ? sdo : (m_oe ? m_data : float_bit);
  usart_sync_slave DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock_pin(ck), .serial_data_in(line), .serial_data_out(sdo),
    .serial_data_oe(sdo_oe), .core_sleeping(core_sleeping), .interrupt_request(irq),
    .wake_core(wake), .take_vector(vtake), .vector_address(vec));
  shift_master u_master (.data_line(line), .shift_clock(ck), .data_drive(m_data),
    .data_oe(m_oe));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    float_bit <= ~float_bit;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ---------------------------------------------
  // apb master: hold the request until pready
  // ---------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    core_sleeping = 1'b0;
    float_bit = 1'b0;
    seed = 32'h00002ca2;
    ridx = '{usart_slave_pkg::IDX_INTERRUPT_CONTROL, usart_slave_pkg::IDX_PERIPHERAL_IRQ_FLAGS,
      usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, usart_slave_pkg::IDX_TRANSMIT_HOLDING,
      usart_slave_pkg::IDX_RECEIVE_BUFFER, usart_slave_pkg::IDX_PERIPHERAL_IRQ_ENABLES,
      usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL, usart_slave_pkg::IDX_BAUD_DIVISOR};
    rval = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ridx[i], 32'h0);
      check("reset value", 32'(rval[i]), rd);
    end
    apb(1'b0, 8'h01, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    $display("test reset done");
    // ---------------------------------------------
    // two words queued, then shifted out asleep
    // ---------------------------------------------
    apb(1'b1, usart_slave_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 32'h10);
    apb(1'b1, usart_slave_pkg::IDX_INTERRUPT_CONTROL, 32'hc0);
    apb(1'b1, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h80);
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL, 32'h30);
    tx0 = xorshift();
    tx1 = xorshift();
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_HOLDING, {24'h0, tx0[7:0]});
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_HOLDING, {24'h0, tx1[7:0]});
    core_sleeping <= 1'b1;
    apb(1'b0, usart_slave_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h0);
    check("flag while held", 32'h0, 32'(rd[4]));
    check("irq while held", 32'h0, 32'(irq));
    u_master.frame(8, 1'b0, 9'h000, got);
    check("tx first word", {24'h0, tx0[7:0]}, 32'(got[7:0]));
    repeat (4) @(posedge pclk);
    check("tx irq", 32'h1, 32'(irq));
    check("tx wake", 32'h1, 32'(wake));
    check("tx vector taken", 32'h1, 32'(vtake));
    check("vector", 32'h0004, 32'(vec));
    u_master.frame(8, 1'b0, 9'h000, got);
    check("tx second word", {24'h0, tx1[7:0]}, 32'(got[7:0]));
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL, {24'h0, 7'h38, tx0[8]});
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_HOLDING, {24'h0, tx0[7:0]});
    u_master.frame(9, 1'b0, 9'h000, got);
    check("tx nine-bit word", 32'(tx0[8:0]), 32'(got));
    $display("test transmit done");
    // ---------------------------------------------
    // nine-bit receive into the fifo, then overrun
    // ---------------------------------------------
    apb(1'b1, usart_slave_pkg::IDX_TRANSMIT_STATUS_CONTROL, 32'h10);
    apb(1'b1, usart_slave_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 32'h20);
    apb(1'b1, usart_slave_pkg::IDX_INTERRUPT_CONTROL, 32'h40);
    apb(1'b1, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'hf0);
    for (int i = 0; i < 3; i++) begin
      w = 9'(xorshift());
      if (i == 0) got = w;
      u_master.frame(9, 1'b1, w, tx1[8:0]);
      if (rx_model.size() < 2) rx_model.push_back(w);
      repeat (4) @(posedge pclk);
      check("rx irq", 32'h1, 32'(irq));
      check("rx wake", 32'h1, 32'(wake));
      check("rx vector taken", 32'h0, 32'(vtake));
    end
    apb(1'b0, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h0);
    check("status after overrun", {24'h0, 7'h79, got[8]}, rd);
    while (rx_model.size() > 0) begin
      w = rx_model.pop_front();
      apb(1'b0, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h0);
      check("ninth bit", 32'(w[8]), 32'(rd[0]));
      apb(1'b0, usart_slave_pkg::IDX_RECEIVE_BUFFER, 32'h0);
      check("rx byte", {24'h0, w[7:0]}, rd);
    end
    apb(1'b0, usart_slave_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h0);
    check("rx flag after drain", 32'h0, 32'(rd[5]));
    apb(1'b1, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'hc0);
    apb(1'b0, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h0);
    check("overrun cleared", 32'h0, 32'(rd[1]));
    apb(1'b1, usart_slave_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'hd0);
    w = 9'(xorshift());
    u_master.frame(9, 1'b1, w, got);
    repeat (4) @(posedge pclk);
    apb(1'b0, usart_slave_pkg::IDX_RECEIVE_BUFFER, 32'h0);
    check("rx after clear", {24'h0, w[7:0]}, rd);
    $display("test receive done");
    end_of_test();
  end
endmodule : usart_sync_slave_mode_tb
